// >>> core/atmrc_ctrl.sv
// Top of the converter trigger, monitor and result control block with its Wishbone register slave.
// Assumes a classic Wishbone master on clock and a converter core that reports results as pulses.
//
// Design decisions made here: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module atmrc_ctrl (
   input wire logic clock,
   input wire logic rstn,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [atmrc_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [atmrc_pkg::DATA_W-1:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [atmrc_pkg::DATA_W-1:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic ext_trigger,
   input wire logic timer5_match,
   input wire logic timer6_match,
   input wire logic conv_result_valid,
   input wire logic [atmrc_pkg::DEST_W-1:0] conv_result_dest,
   input wire logic [atmrc_pkg::RES_W-1:0] conv_result_value,
   output logic top_prio_hw_start,
   output logic normal_hw_start,
   output logic adc_soft_reset,
   output logic monitor1_irq
);
   import atmrc_pkg::*;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   // ----------------------------------------
   // Register state
   // ----------------------------------------
   logic top_sel_reg;
   logic top_en_reg;
   logic nrm_sel_reg;
   logic nrm_en_reg;
   atmrc_key_state_t key_state_reg;
   logic soft_reset_reg;
   logic mon_dir_reg;
   logic [DEST_W-1:0] mon_tgt_reg;
   logic mon_en_reg;
   logic [RES_W-1:0] cmp_reg;
   logic [RES_W-1:0] res0_value_reg;
   logic res0_ovr_reg;
   logic res0_stored_reg;
   logic ack_reg;
   logic [DATA_W-1:0] dat_reg;
   logic [CH_N-1:0] start_vec;
   logic irq_wire;

   logic req;
   logic wr_lo;
   logic wr_hi;
   logic rd_res0;
   logic res0_wr;
   logic key_fire;
   logic [DATA_W-1:0] rd_data;

   atmrc_res_if res_bus ();

   assign res_bus.valid = conv_result_valid;
   assign res_bus.dest = conv_result_dest;
   assign res_bus.value = conv_result_value;

   // ----------------------------------------
   // Bus decode
   // ----------------------------------------
   always_comb begin
      req = wb_cyc_i && wb_stb_i && !ack_reg;
      wr_lo = req && wb_we_i && wb_sel_i[0];
      wr_hi = req && wb_we_i && wb_sel_i[1];
      rd_res0 = req && !wb_we_i && (wb_adr_i == OFS_RES0);
      res0_wr = conv_result_valid && (conv_result_dest == DEST_RES0);
      key_fire = wr_lo && (wb_adr_i == OFS_TRIG) && (key_state_reg == KEY_ARMED) &&
                 (wb_dat_i[KEY_MSB:KEY_LSB] == KEY_FIRE);
   end

   always_comb begin
      rd_data = DATA_ZERO;
      case (wb_adr_i)
         OFS_TRIG: begin
            // Key field is write-only and reads back as zero
            rd_data[TRIG_TOP_SEL_BIT] = top_sel_reg;
            rd_data[TRIG_TOP_EN_BIT] = top_en_reg;
            rd_data[TRIG_NRM_SEL_BIT] = nrm_sel_reg;
            rd_data[TRIG_NRM_EN_BIT] = nrm_en_reg;
         end
         OFS_MON1: begin
            rd_data[MON_DIR_BIT] = mon_dir_reg;
            rd_data[MON_TGT_MSB:MON_TGT_LSB] = mon_tgt_reg;
            rd_data[MON_EN_BIT] = mon_en_reg;
         end
         OFS_RES0: begin
            rd_data[RES_VAL_MSB:RES_VAL_LSB] = res0_value_reg;
            rd_data[RES_OVR_BIT] = res0_ovr_reg;
            rd_data[RES_STORED_BIT] = res0_stored_reg;
         end
         OFS_CMP1: begin
            rd_data[CMP_MSB:0] = cmp_reg;
         end
         default: begin
            rd_data = DATA_ZERO;
         end
      endcase
   end

   // ----------------------------------------
   // Bus answer
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn) begin
         ack_reg <= BIT_RST;
         dat_reg <= DATA_ZERO;
      end else begin
         ack_reg <= req;
         dat_reg <= (req && !wb_we_i) ? rd_data : DATA_ZERO;
      end
   end

   // ----------------------------------------
   // Trigger control register
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn || soft_reset_reg) begin
         top_sel_reg <= SRC_EXT;
         top_en_reg <= BIT_RST;
         nrm_sel_reg <= SRC_EXT;
         nrm_en_reg <= BIT_RST;
      end else if (wr_lo && (wb_adr_i == OFS_TRIG)) begin
         top_sel_reg <= wb_dat_i[TRIG_TOP_SEL_BIT];
         top_en_reg <= wb_dat_i[TRIG_TOP_EN_BIT];
         nrm_sel_reg <= wb_dat_i[TRIG_NRM_SEL_BIT];
         nrm_en_reg <= wb_dat_i[TRIG_NRM_EN_BIT];
      end
   end

   // ----------------------------------------
   // Software reset key sequence
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn || soft_reset_reg) begin
         key_state_reg <= KEY_IDLE;
      end else if (wr_lo && (wb_adr_i == OFS_TRIG)) begin
         case (key_state_reg)
            KEY_IDLE: begin
               key_state_reg <= (wb_dat_i[KEY_MSB:KEY_LSB] == KEY_ARM) ? KEY_ARMED : KEY_IDLE;
            end
            KEY_ARMED: begin
               key_state_reg <= (wb_dat_i[KEY_MSB:KEY_LSB] == KEY_ARM) ? KEY_ARMED : KEY_IDLE;
            end
            default: begin
               key_state_reg <= KEY_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         soft_reset_reg <= BIT_RST;
      end else begin
         // The core keeps its conversion clock setting across this pulse
         soft_reset_reg <= key_fire;
      end
   end

   // ----------------------------------------
   // Monitor 1 control and comparison value
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn || soft_reset_reg) begin
         mon_dir_reg <= BIT_RST;
         mon_tgt_reg <= TGT_RST;
         mon_en_reg <= BIT_RST;
      end else if (wr_lo && (wb_adr_i == OFS_MON1)) begin
         mon_dir_reg <= wb_dat_i[MON_DIR_BIT];
         mon_tgt_reg <= wb_dat_i[MON_TGT_MSB:MON_TGT_LSB];
         mon_en_reg <= wb_dat_i[MON_EN_BIT];
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || soft_reset_reg) begin
         cmp_reg <= RES_RST;
      end else if (wb_adr_i == OFS_CMP1) begin
         if (wr_lo) begin
            cmp_reg[7:0] <= wb_dat_i[7:0];
         end
         if (wr_hi) begin
            cmp_reg[CMP_MSB:8] <= wb_dat_i[CMP_MSB:8];
         end
      end
   end

   // ----------------------------------------
   // Result register 0
   // ----------------------------------------
   always_ff @(posedge clock) begin
      if (!rstn || soft_reset_reg) begin
         res0_value_reg <= RES_RST;
      end else if (res0_wr) begin
         res0_value_reg <= conv_result_value;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || soft_reset_reg) begin
         res0_stored_reg <= BIT_RST;
      end else if (res0_wr) begin
         res0_stored_reg <= 1'b1;
      end else if (rd_res0) begin
         res0_stored_reg <= BIT_RST;
      end
   end

   always_ff @(posedge clock) begin
      if (!rstn || soft_reset_reg) begin
         res0_ovr_reg <= BIT_RST;
      end else if (res0_wr && res0_stored_reg && !rd_res0) begin
         res0_ovr_reg <= 1'b1;
      end else if (rd_res0) begin
         res0_ovr_reg <= BIT_RST;
      end
   end

   // ----------------------------------------
   // Start selection and monitor
   // ----------------------------------------
   atmrc_start_sel u_start (
      .clock(clock),
      .rstn(rstn),
      .src_sel({nrm_sel_reg, top_sel_reg}),
      .start_en({nrm_en_reg, top_en_reg}),
      .ext_trigger(ext_trigger),
      .timer_match({timer6_match, timer5_match}),
      .start_reg(start_vec)
   );

   atmrc_monitor u_mon (
      .clock(clock),
      .rstn(rstn),
      .mon_en(mon_en_reg),
      .mon_dir(mon_dir_reg),
      .mon_target(mon_tgt_reg),
      .cmp_value(cmp_reg),
      .res(res_bus.mon),
      .irq_reg(irq_wire)
   );

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = dat_reg;
   assign adc_soft_reset = soft_reset_reg;
   assign top_prio_hw_start = start_vec[CH_TOP];
   assign normal_hw_start = start_vec[CH_NRM];
   assign monitor1_irq = irq_wire;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   sequence s_arm_write;
      wr_lo && wb_adr_i == OFS_TRIG && wb_dat_i[KEY_MSB:KEY_LSB] == KEY_ARM;
   endsequence

   sequence s_fire_write;
      wr_lo && wb_adr_i == OFS_TRIG && wb_dat_i[KEY_MSB:KEY_LSB] == KEY_FIRE;
   endsequence

   chk_top_start_timer: assert property (
      (top_en_reg && top_sel_reg && timer5_match) |=> top_prio_hw_start)
      else $error("top-priority start missed a timer 5 match");

   chk_top_start_gate: assert property (
      top_prio_hw_start |-> $past(top_en_reg && (top_sel_reg ? timer5_match : ext_trigger)))
      else $error("top-priority start without an enabled source");

   chk_nrm_start_ext: assert property (
      (nrm_en_reg && !nrm_sel_reg && ext_trigger) |=> normal_hw_start)
      else $error("normal start missed the external trigger");

   chk_nrm_start_gate: assert property (
      !nrm_en_reg |=> !normal_hw_start)
      else $error("normal start while hardware start disabled");

   chk_key_arm_step: assert property (
      (!soft_reset_reg) ##0 s_arm_write |=> key_state_reg == KEY_ARMED)
      else $error("arm write did not arm the key");

   chk_key_fire_seq: assert property (
      (key_state_reg == KEY_ARMED) ##0 s_fire_write |=> adc_soft_reset)
      else $error("armed fire write gave no software reset");

   chk_key_gives_reset: assert property (
      adc_soft_reset |-> $past(key_state_reg == KEY_ARMED && wr_lo && wb_adr_i == OFS_TRIG))
      else $error("software reset without an armed key");

   chk_reset_clears: assert property (
      adc_soft_reset |=> !top_en_reg && !nrm_en_reg && !mon_en_reg && mon_tgt_reg == TGT_RST && !res0_stored_reg)
      else $error("software reset left a register set");

   chk_res0_zero_bits: assert property (
      $past(rd_res0) |-> wb_ack_o && wb_dat_o[DATA_W-1:RES_VAL_MSB+1] == 16'h0000 &&
                         wb_dat_o[RES_VAL_LSB-1:RES_OVR_BIT+1] == 4'h0)
      else $error("result register reserved bits not zero");

   chk_res0_overrun: assert property (
      (res0_wr && res0_stored_reg && !rd_res0 && !soft_reset_reg) |=> res0_ovr_reg ##1 1'b1)
      else $error("overrun flag not set on overwrite");

   chk_res0_stored: assert property (
      (res0_wr && !soft_reset_reg) |=> res0_stored_reg && res0_value_reg == $past(conv_result_value))
      else $error("result not stored with flag");

   chk_res0_read_clear: assert property (
      (rd_res0 && !res0_wr && !soft_reset_reg) |=> !res0_stored_reg && !res0_ovr_reg)
      else $error("result flags not cleared by read");

endmodule

`default_nettype wire

// >>> core/atmrc_pkg.sv
// Constants, register map and types of the converter trigger, monitor and result control block.
// Assumes one 250 MHz clock, a classic Wishbone slave port and a converter core that reports results.

package atmrc_pkg;

   // ----------------------------------------
   // Widths
   // ----------------------------------------
   localparam int unsigned ADR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned RES_W = 10;
   localparam int unsigned DEST_W = 4;
   localparam int unsigned KEY_W = 2;
   localparam int unsigned CH_N = 2;

   // ----------------------------------------
   // Register byte offsets
   // ----------------------------------------
   localparam logic [ADR_W-1:0] OFS_TRIG = 8'h00;
   localparam logic [ADR_W-1:0] OFS_MON1 = 8'h04;
   localparam logic [ADR_W-1:0] OFS_RES0 = 8'h08;
   localparam logic [ADR_W-1:0] OFS_CMP1 = 8'h0C;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned TRIG_TOP_SEL_BIT = 7;
   localparam int unsigned TRIG_TOP_EN_BIT = 6;
   localparam int unsigned TRIG_NRM_SEL_BIT = 5;
   localparam int unsigned TRIG_NRM_EN_BIT = 4;
   localparam int unsigned KEY_MSB = 1;
   localparam int unsigned KEY_LSB = 0;
   localparam int unsigned MON_DIR_BIT = 5;
   localparam int unsigned MON_TGT_MSB = 4;
   localparam int unsigned MON_TGT_LSB = 1;
   localparam int unsigned MON_EN_BIT = 0;
   localparam int unsigned RES_VAL_MSB = 15;
   localparam int unsigned RES_VAL_LSB = 6;
   localparam int unsigned RES_OVR_BIT = 1;
   localparam int unsigned RES_STORED_BIT = 0;
   localparam int unsigned CMP_MSB = 9;
   localparam int unsigned CH_TOP = 0;
   localparam int unsigned CH_NRM = 1;

   // ----------------------------------------
   // Codes and reset values
   // ----------------------------------------
   localparam logic [KEY_W-1:0] KEY_ARM = 2'h2;
   localparam logic [KEY_W-1:0] KEY_FIRE = 2'h1;
   localparam logic [DEST_W-1:0] DEST_TOP = 4'h8;
   localparam logic [DEST_W-1:0] DEST_RES0 = 4'h0;
   localparam logic SRC_EXT = 1'b0;
   localparam logic SRC_TIMER = 1'b1;
   localparam logic BIT_RST = 1'b0;
   localparam logic [DEST_W-1:0] TGT_RST = 4'h0;
   localparam logic [RES_W-1:0] RES_RST = 10'h000;
   localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

   typedef enum logic [0:0] {
      KEY_IDLE = 1'b0,
      KEY_ARMED = 1'b1
   } atmrc_key_state_t;

endpackage

// >>> core/atmrc_res_if.sv
// Result report path from the converter core to the monitor.
// Assumes the top module drives it from its result inputs.
`timescale 1ns/1ps
`default_nettype none

interface atmrc_res_if;
   import atmrc_pkg::*;
   logic valid;
   logic [DEST_W-1:0] dest;
   logic [RES_W-1:0] value;
   modport src (output valid, output dest, output value);
   modport mon (input valid, input dest, input value);
endinterface

`default_nettype wire

// >>> core/atmrc_start_sel.sv
// Hardware start source selection for the top-priority and normal channels.
// Assumes trigger and timer match inputs are one-cycle pulses synchronous to clock.
`timescale 1ns/1ps
`default_nettype none

module atmrc_start_sel (
   input wire logic clock,
   input wire logic rstn,
   input wire logic [atmrc_pkg::CH_N-1:0] src_sel,
   input wire logic [atmrc_pkg::CH_N-1:0] start_en,
   input wire logic ext_trigger,
   input wire logic [atmrc_pkg::CH_N-1:0] timer_match,
   output logic [atmrc_pkg::CH_N-1:0] start_reg
);
   import atmrc_pkg::*;

   // ----------------------------------------
   // One selector per channel
   // ----------------------------------------
   genvar ch;
   generate
      for (ch = 0; ch < CH_N; ch = ch + 1) begin : g_ch
         always_ff @(posedge clock) begin
            if (!rstn) begin
               start_reg[ch] <= BIT_RST;
            end else begin
               start_reg[ch] <= start_en[ch] & ((src_sel[ch] == SRC_TIMER) ? timer_match[ch] : ext_trigger);
            end
         end
      end
   endgenerate

endmodule

`default_nettype wire

// >>> core/atmrc_monitor.sv
// Monitor function 1: compares new results of the picked register against comparison register 1.
// Assumes results arrive as one-cycle reports on the result interface.
`timescale 1ns/1ps
`default_nettype none

module atmrc_monitor (
   input wire logic clock,
   input wire logic rstn,
   input wire logic mon_en,
   input wire logic mon_dir,
   input wire logic [atmrc_pkg::DEST_W-1:0] mon_target,
   input wire logic [atmrc_pkg::RES_W-1:0] cmp_value,
   atmrc_res_if.mon res,
   output logic irq_reg
);
   import atmrc_pkg::*;

   logic [DEST_W-1:0] target_dest;
   logic hit;

   // ----------------------------------------
   // Target decode and compare
   // ----------------------------------------
   always_comb begin
      target_dest = mon_target[DEST_W-1] ? DEST_TOP : {1'b0, mon_target[DEST_W-2:0]};
      hit = res.valid && (res.dest == target_dest) &&
            (mon_dir ? (res.value > cmp_value) : (res.value < cmp_value));
   end

   always_ff @(posedge clock) begin
      if (!rstn) begin
         irq_reg <= BIT_RST;
      end else begin
         irq_reg <= mon_en & hit;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   chk_mon_irq_cause: assert property (@(posedge clock) disable iff (!rstn)
      irq_reg |-> $past(mon_en && res.valid && res.dest == target_dest))
      else $error("monitor interrupt without a matching new result");

   chk_mon_quiet: assert property (@(posedge clock) disable iff (!rstn)
      !mon_en |=> !irq_reg)
      else $error("monitor interrupt while monitor disabled");

   chk_mon_direction: assert property (@(posedge clock) disable iff (!rstn)
      (mon_en && res.valid && res.dest == target_dest && !mon_dir && res.value < cmp_value) |=> irq_reg)
      else $error("monitor missed a below-comparison result");

endmodule

`default_nettype wire

// >>> verif/atmrc_core_model.sv
// Behavioural stand-in for the converter core and the timer match outputs.
// Assumes the bench calls its tasks from one process, one pulse at a time.
`timescale 1ns/1ps
`default_nettype none

module atmrc_core_model (
   input wire logic clock,
   output logic ext_trigger,
   output logic timer5_match,
   output logic timer6_match,
   output logic conv_result_valid,
   output logic [atmrc_pkg::DEST_W-1:0] conv_result_dest,
   output logic [atmrc_pkg::RES_W-1:0] conv_result_value
);
   import atmrc_pkg::*;

   initial begin
      ext_trigger = 1'h0;
      timer5_match = 1'h0;
      timer6_match = 1'h0;
      conv_result_valid = 1'h0;
      conv_result_dest = 4'hF;
      conv_result_value = 10'h3FF;
   end

   // One-cycle pulse on source 0 external, 1 timer 5, 2 timer 6
   task automatic trig(input logic [1:0] which);
      @(posedge clock);
      ext_trigger <= (which == 2'h0);
      timer5_match <= (which == 2'h1);
      timer6_match <= (which == 2'h2);
      @(posedge clock);
      ext_trigger <= 1'h0;
      timer5_match <= 1'h0;
      timer6_match <= 1'h0;
   endtask

   // Released result lines show the inverse, never the stale value
   task automatic report(input logic [DEST_W-1:0] dest, input logic [RES_W-1:0] value);
      @(posedge clock);
      conv_result_valid <= 1'h1;
      conv_result_dest <= dest;
      conv_result_value <= value;
      @(posedge clock);
      conv_result_valid <= 1'h0;
      conv_result_dest <= ~dest;
      conv_result_value <= ~value;
   endtask
endmodule

`default_nettype wire

// >>> verif/testbench.sv
// Self-checking bench for the trigger, monitor and result control block.
// Assumes the core model drives triggers and results; Wishbone master lives here.
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import atmrc_pkg::*;

   logic clock = 1'h0;
   logic rstn = 1'h0;
   logic wb_cyc_i = 1'h0;
   logic wb_stb_i = 1'h0;
   logic wb_we_i = 1'h0;
   logic [ADR_W-1:0] wb_adr_i = 8'h00;
   logic [DATA_W-1:0] wb_dat_i = 32'h0000_0000;
   logic [3:0] wb_sel_i = 4'h0;
   logic [DATA_W-1:0] wb_dat_o;
   logic wb_ack_o, ext_trigger, timer5_match, timer6_match, conv_result_valid;
   logic [DEST_W-1:0] conv_result_dest;
   logic [RES_W-1:0] conv_result_value;
   logic top_prio_hw_start, normal_hw_start, adc_soft_reset, monitor1_irq;
   logic [31:0] rd;
   logic [7:0] cfgs [4] = '{8'hD0, 8'h70, 8'h00, 8'hE0};
   int errors = 0;
   int cmp_count = 0;
   int srst_cnt = 0;

   always #2 clock = ~clock;

   atmrc_ctrl DUT (.clock(clock), .rstn(rstn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_trigger(ext_trigger),
      .timer5_match(timer5_match), .timer6_match(timer6_match),
      .conv_result_valid(conv_result_valid), .conv_result_dest(conv_result_dest),
      .conv_result_value(conv_result_value), .top_prio_hw_start(top_prio_hw_start),
      .normal_hw_start(normal_hw_start), .adc_soft_reset(adc_soft_reset),
      .monitor1_irq(monitor1_irq));

   atmrc_core_model core (.clock(clock), .ext_trigger(ext_trigger), .timer5_match(timer5_match),
      .timer6_match(timer6_match), .conv_result_valid(conv_result_valid),
      .conv_result_dest(conv_result_dest), .conv_result_value(conv_result_value));

   always @(posedge clock) begin
      if (adc_soft_reset === 1'h1) begin
         srst_cnt <= srst_cnt + 1;
      end
   end

   // ----------------------------------------
   // Reporting
   // ----------------------------------------
   task automatic final_report();
      $display("errors=%0d cmp_count=%0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ----------------------------------------
   // Wishbone classic master
   // ----------------------------------------
   task automatic wb_xfer(input logic we, input logic [ADR_W-1:0] adr, input logic [31:0] wdat,
                          output logic [31:0] rdat);
      int n;
      @(posedge clock);
      wb_cyc_i <= 1'h1;
      wb_stb_i <= 1'h1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= wdat;
      wb_sel_i <= 4'hF;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (wb_ack_o !== 1'h1 && n < 50);
      if (wb_ack_o !== 1'h1) begin
         errors++;
         final_report();
      end
      rdat = wb_dat_o;
      wb_cyc_i <= 1'h0;
      wb_stb_i <= 1'h0;
   endtask

   task automatic wb_write(input logic [ADR_W-1:0] adr, input logic [31:0] wdat);
      logic [31:0] dummy;
      wb_xfer(1'h1, adr, wdat, dummy);
   endtask

   task automatic rd_chk(input logic [ADR_W-1:0] adr, input logic [31:0] exp);
      logic [31:0] v;
      wb_xfer(1'h0, adr, 32'h0000_0000, v);
      chk_word(v, exp);
   endtask

   // ----------------------------------------
   // Scenario helpers
   // ----------------------------------------
   task automatic start_case(input logic [7:0] cfg, input logic [1:0] src);
      core.trig(src);
      #1;
      chk_bit(top_prio_hw_start, cfg[6] & (cfg[7] ? src == 2'h1 : src == 2'h0));
      chk_bit(normal_hw_start, cfg[4] & (cfg[5] ? src == 2'h2 : src == 2'h0));
   endtask

   task automatic mon_case(input logic dir, input logic [3:0] tgt, input logic en,
                           input logic [3:0] dest, input logic [9:0] val, input logic exp);
      wb_write(OFS_MON1, {26'h0, dir, tgt, en});
      rd_chk(OFS_MON1, {26'h0, dir, tgt, en});
      core.report(dest, val);
      #1;
      chk_bit(monitor1_irq, exp);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (5) @(posedge clock);
      rstn <= 1'h1;
      rd_chk(OFS_TRIG, 32'h0000_0000);
      rd_chk(OFS_MON1, 32'h0000_0000);
      rd_chk(OFS_RES0, 32'h0000_0000);
      wb_write(8'h40, 32'hFFFF_FFFF);
      rd_chk(8'h40, 32'h0000_0000);
      // Top and normal never both take the external trigger
      for (int c = 0; c < 4; c++) begin
         wb_write(OFS_TRIG, {24'h000000, cfgs[c]});
         rd_chk(OFS_TRIG, {24'h000000, cfgs[c]});
         for (int s = 0; s < 3; s++) begin
            start_case(cfgs[c], s[1:0]);
         end
      end
      wb_write(OFS_TRIG, 32'h0000_0000);
      core.report(4'h0, 10'h2A5);
      rd_chk(OFS_RES0, 32'h0000_A941);
      core.report(4'h0, 10'h155);
      core.report(4'h0, 10'h3FF);
      rd_chk(OFS_RES0, 32'h0000_FFC3);
      rd_chk(OFS_RES0, 32'h0000_FFC0);
      core.report(4'h3, 10'h001);
      wb_write(OFS_RES0, 32'hFFFF_FFFF);
      rd_chk(OFS_RES0, 32'h0000_FFC0);
      wb_write(OFS_CMP1, 32'h0000_0100);
      mon_case(1'h0, 4'h0, 1'h1, 4'h0, 10'h0FF, 1'h1);
      mon_case(1'h0, 4'h0, 1'h1, 4'h0, 10'h100, 1'h0);
      mon_case(1'h1, 4'h0, 1'h1, 4'h0, 10'h101, 1'h1);
      mon_case(1'h1, 4'h3, 1'h1, 4'h3, 10'h200, 1'h1);
      mon_case(1'h1, 4'h3, 1'h1, 4'h0, 10'h200, 1'h0);
      mon_case(1'h1, 4'h9, 1'h1, 4'h8, 10'h200, 1'h1);
      mon_case(1'h1, 4'h7, 1'h1, 4'h7, 10'h3FF, 1'h1);
      mon_case(1'h1, 4'h0, 1'h0, 4'h0, 10'h200, 1'h0);
      wb_write(OFS_TRIG, 32'h0000_0002);
      wb_write(OFS_TRIG, 32'h0000_0003);
      wb_write(OFS_TRIG, 32'h0000_0001);
      rd_chk(OFS_TRIG, 32'h0000_0000);
      chk_word(srst_cnt, 32'h0000_0000);
      wb_write(OFS_TRIG, 32'h0000_00D2);
      rd_chk(OFS_TRIG, 32'h0000_00D0);
      wb_write(OFS_MON1, 32'h0000_003F);
      // Fire write also sets the control bits, so only the reset can clear them
      wb_write(OFS_TRIG, 32'h0000_00D1);
      rd_chk(OFS_TRIG, 32'h0000_0000);
      chk_word(srst_cnt, 32'h0000_0001);
      rd_chk(OFS_MON1, 32'h0000_0000);
      rd_chk(OFS_RES0, 32'h0000_0000);
      rd_chk(OFS_CMP1, 32'h0000_0000);
      final_report();
   end
endmodule

`default_nettype wire
